// [ckec_defines.svh]
/*
 Constants and the operation list for the console key edit controller.
 Assumes a 200 MHz system clock and keys that are raw, bouncing pins.
*/
// Operation
// - Style zero selects standard display flow
// - Style one adds bank selection displays
// - Shift while advance held steps backward
// - Advance plus shift held 2 s ignored
// - Arrow on number edits least digit
// - Arrow on string flashes whole string
// - Number edit: up/down value, shift digit
// - String edit: up/down next/previous choice
// - Two seconds idle commits the edit
// - Locked item never flashes or changes
// - Run/ready on digital input refuses keys
// - Advance during flash discards, shows next
// - Mode during flash discards, shows operation
// - Manual output value keeps flashing, drives output
// - Advance held 2 s enters setup, or bank in style one
// - Mode held 1 s runs mode function
`ifndef CKEC_DEFINES_SVH
`define CKEC_DEFINES_SVH
`define CKEC_CLK_HZ 200000000
`define CKEC_DEBOUNCE_MS 10
`define CKEC_HOLD2_MS 2000
`define CKEC_HOLD1_MS 1000
`define CKEC_ITEM_W 6
`define CKEC_VAL_W 16
`define CKEC_DIGITS 4
`define CKEC_STYLE_STD 1'b0
`define CKEC_STYLE_SPECIAL 1'b1
`define CKEC_GRP_OPER 2'h0
`define CKEC_GRP_MODE 2'h1
`define CKEC_GRP_SETUP 2'h2
`define CKEC_GRP_BANK 2'h3
`endif

// [ckec_pkg.sv]
/*
 Types for the console key edit controller.
 Assumes nothing beyond the defines header.
*/
package ckec_pkg;
   typedef enum logic [1:0] {
      ckec_idle,
      ckec_edit_num,
      ckec_edit_str
   } ckec_state_type;
endpackage : ckec_pkg

// [ckec_top.sv]
/*
 Console key edit controller: debounce, navigation and edit cycle.
 Assumes item attributes come from a lookup outside, combinationally
 from o_item_group and o_item_index on the same clock.
*/
`include "ckec_defines.svh"
module ckec_top #(
   parameter int unsigned DEBOUNCE_CYC =
      `CKEC_CLK_HZ / 1000 * `CKEC_DEBOUNCE_MS,
   parameter int unsigned HOLD2_CYC =
      `CKEC_CLK_HZ / 1000 * `CKEC_HOLD2_MS,
   parameter int unsigned HOLD1_CYC =
      `CKEC_CLK_HZ / 1000 * `CKEC_HOLD1_MS
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // Keys from the panel: advance, mode, shift, down, up
   input wire logic i_key_para,
   input wire logic i_key_mode,
   input wire logic i_key_shift,
   input wire logic i_key_down,
   input wire logic i_key_up,
   // Setup values
   input wire logic i_key_flow_style_setting,
   input wire logic i_digital_input_assignment,
   input wire logic i_manual_mode,
   // Attributes of the current item
   input wire logic i_item_present,
   input wire logic i_item_last,
   input wire logic i_item_editable,
   input wire logic i_item_is_string,
   input wire logic i_item_is_runready,
   input wire logic i_item_is_mv,
   input wire logic [`CKEC_VAL_W-1:0] i_item_value,
   input wire logic [`CKEC_VAL_W-1:0] i_choice_count,
   // Display position and edit outputs
   output logic [1:0] o_item_group,
   output logic [`CKEC_ITEM_W-1:0] o_item_index,
   output logic o_flashing,
   output logic [`CKEC_DIGITS-1:0] o_flash_digits,
   output logic [`CKEC_VAL_W-1:0] o_edit_value,
   output logic o_commit,
   output logic o_mode_function,
   output logic o_mv_drive,
   output logic [`CKEC_VAL_W-1:0] o_manipulated_output_value
);
   localparam int NKEY = 5;
   localparam logic [`CKEC_ITEM_W-1:0] ITEM_ONE = `CKEC_ITEM_W'(1);
   localparam logic [`CKEC_VAL_W-1:0] VAL_ONE = `CKEC_VAL_W'(1);
   localparam logic [`CKEC_DIGITS-1:0] DIG_FIRST = `CKEC_DIGITS'(1);

   logic [NKEY-1:0] raw;
   logic [NKEY-1:0] sync1;
   logic [NKEY-1:0] sync2;
   wire logic [NKEY-1:0] key;
   logic [NKEY-1:0] key_d;
   logic [NKEY-1:0] rise;
   logic [NKEY-1:0] fall;
   assign raw = {i_key_up, i_key_down, i_key_shift, i_key_mode, i_key_para};

   // Two-stage sync then per-key stability counter
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NKEY; g++) begin : g_deb
         logic [31:0] cnt;
         logic kq;
         assign key[g] = kq;
         always_ff @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
               cnt <= '0;
               kq <= 1'b0;
            end else if (sync2[g] == kq) begin
               cnt <= '0;
            end else if (cnt >= DEBOUNCE_CYC - 1) begin
               cnt <= '0;
               kq <= sync2[g];
            end else begin
               cnt <= cnt + 32'd1;
            end
         end
      end
   endgenerate

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         key_d <= '0;
      end else begin
         key_d <= key;
      end
   end
   assign rise = key & ~key_d;
   assign fall = ~key & key_d;

   wire k_para = key[0];
   wire k_mode = key[1];
   wire r_para = rise[0];
   wire r_mode = rise[1];
   wire r_shift = rise[2];
   wire r_down = rise[3];
   wire r_up = rise[4];
   wire f_para = fall[0];
   wire any_key = |key;
   wire arrow = r_shift | r_down | r_up;

   ckec_pkg::ckec_state_type state;
   ckec_pkg::ckec_state_type next_state;
   logic [31:0] para_hold;
   logic [31:0] mode_hold;
   logic [31:0] idle_cnt;
   logic chord;
   logic para_long;
   logic mode_fired;
   logic mode_armed;
   logic step_pending;
   logic step_back;
   logic mv_hold;

   // Hold timers measured from clean edges
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         para_hold <= '0;
         mode_hold <= '0;
         idle_cnt <= '0;
      end else begin
         para_hold <= k_para ? para_hold + 32'd1 : 32'd0;
         mode_hold <= k_mode ? mode_hold + 32'd1 : 32'd0;
         idle_cnt <= (any_key || state == ckec_pkg::ckec_idle) ?
            32'd0 : idle_cnt + 32'd1;
      end
   end

   wire in_edit = state != ckec_pkg::ckec_idle;
   wire at_oper = o_item_group == `CKEC_GRP_OPER;
   wire hold2 = para_hold == HOLD2_CYC - 1;
   wire idle_done = idle_cnt == HOLD2_CYC - 1;
   // Refuse run/ready edits when a digital input owns it
   wire can_edit = i_item_editable &
      ~(i_item_is_runready & i_digital_input_assignment);
   wire start_edit = ~in_edit & ~k_para & ~k_mode & arrow & can_edit;
   // Chord shift while advance held: reverse, unless held long
   wire rev_press = k_para & r_shift;
   wire next_group_bank = i_key_flow_style_setting == `CKEC_STYLE_SPECIAL;
   // Skip absent items one clock at a time after a step
   wire skip = step_pending & ~i_item_present;
   wire step_now = (f_para & ~chord & ~para_long) | skip;

   always_comb begin
      next_state = state;
      case (state)
         ckec_pkg::ckec_idle: begin
            if (start_edit) begin
               next_state = i_item_is_string ? ckec_pkg::ckec_edit_str :
                  ckec_pkg::ckec_edit_num;
            end
         end
         ckec_pkg::ckec_edit_num, ckec_pkg::ckec_edit_str: begin
            if (r_para || r_mode) begin
               next_state = ckec_pkg::ckec_idle;
            end else if (idle_done && !mv_hold) begin
               next_state = ckec_pkg::ckec_idle;
            end
         end
         default: next_state = ckec_pkg::ckec_idle;
      endcase
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state <= ckec_pkg::ckec_idle;
         chord <= 1'b0;
         para_long <= 1'b0;
         step_pending <= 1'b0;
         step_back <= 1'b0;
         o_item_group <= `CKEC_GRP_OPER;
         o_item_index <= '0;
      end else begin
         state <= next_state;
         if (r_para) begin
            chord <= 1'b0;
            para_long <= 1'b0;
         end else if (rev_press) begin
            chord <= 1'b1;
         end
         // Long chord does nothing; long lone advance enters setup, or bank in style one
         if (hold2 && !chord && at_oper && !in_edit) begin
            para_long <= 1'b1;
            o_item_group <= next_group_bank ? `CKEC_GRP_BANK :
               `CKEC_GRP_SETUP;
            o_item_index <= '0;
         end else if (hold2 && chord) begin
            para_long <= 1'b1;
         end else if (rev_press && !para_long && !in_edit) begin
            o_item_index <= o_item_index - ITEM_ONE;
            step_back <= 1'b1;
            step_pending <= 1'b1;
         end else if (step_now && !in_edit) begin
            step_pending <= 1'b1;
            step_back <= step_back & skip;
            if (step_back && skip) begin
               o_item_index <= o_item_index - ITEM_ONE;
            end else if (i_item_last) begin
               o_item_index <= '0;
            end else begin
               o_item_index <= o_item_index + ITEM_ONE;
            end
         end else begin
            step_pending <= 1'b0;
         end
         if (in_edit && r_para) begin
            para_long <= 1'b1; // No second step on release
            o_item_index <= o_item_index + ITEM_ONE;
         end
         if (r_mode && (in_edit || !at_oper)) begin
            o_item_group <= `CKEC_GRP_OPER;
            o_item_index <= '0;
         end
      end
   end

   // Mode function needs a fresh press on the operation display
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         mode_armed <= 1'b0;
         mode_fired <= 1'b0;
         o_mode_function <= 1'b0;
      end else begin
         if (r_mode) begin
            mode_armed <= at_oper && !in_edit;
         end
         mode_fired <= k_mode ? (mode_fired | o_mode_function) : 1'b0;
         o_mode_function <= mode_armed && k_mode && !mode_fired &&
            !o_mode_function && mode_hold == HOLD1_CYC - 1;
      end
   end

   // Edit datapath
   wire [`CKEC_VAL_W-1:0] step_amt;
   wire [`CKEC_VAL_W-1:0] str_next;
   wire [`CKEC_VAL_W-1:0] str_prev;
   assign step_amt = o_flash_digits[3] ? `CKEC_VAL_W'(1000) :
      o_flash_digits[2] ? `CKEC_VAL_W'(100) :
      o_flash_digits[1] ? `CKEC_VAL_W'(10) : VAL_ONE;
   assign str_next = (o_edit_value + VAL_ONE >= i_choice_count) ?
      '0 : o_edit_value + VAL_ONE;
   assign str_prev = (o_edit_value == '0) ?
      i_choice_count - VAL_ONE : o_edit_value - VAL_ONE;
   wire commit_now = in_edit && next_state == ckec_pkg::ckec_idle &&
      !r_para && !r_mode;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_flash_digits <= '0;
         o_edit_value <= '0;
         o_flashing <= 1'b0;
         o_commit <= 1'b0;
         mv_hold <= 1'b0;
         o_mv_drive <= 1'b0;
         o_manipulated_output_value <= '0;
      end else begin
         o_commit <= commit_now;
         o_flashing <= next_state != ckec_pkg::ckec_idle;
         if (start_edit) begin
            o_edit_value <= i_item_value;
            o_flash_digits <= i_item_is_string ? '1 : DIG_FIRST;
            mv_hold <= i_item_is_mv & i_manual_mode;
         end else if (state == ckec_pkg::ckec_edit_num) begin
            if (r_up) begin
               o_edit_value <= o_edit_value + step_amt;
            end else if (r_down) begin
               o_edit_value <= o_edit_value - step_amt;
            end else if (r_shift) begin
               o_flash_digits <= {o_flash_digits[`CKEC_DIGITS-2:0],
                  o_flash_digits[`CKEC_DIGITS-1]};
            end
         end else if (state == ckec_pkg::ckec_edit_str) begin
            if (r_up) begin
               o_edit_value <= str_next;
            end else if (r_down) begin
               o_edit_value <= str_prev;
            end
         end
         if (next_state == ckec_pkg::ckec_idle) begin
            mv_hold <= 1'b0;
         end
         // Manual output follows the flashing value live
         o_mv_drive <= mv_hold && in_edit;
         if (mv_hold && in_edit) begin
            o_manipulated_output_value <= o_edit_value;
         end
      end
   end
endmodule : ckec_top

// [ckec_checker.sv]
/* Port checker for the console key edit controller.
 Bound onto ckec_top from the bench; sees only its ports. */
module ckec_checker #(
   parameter int unsigned HOLD2_CYC = 200
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_key_para,
   input wire logic i_key_mode,
   input wire logic i_key_shift,
   input wire logic i_key_down,
   input wire logic i_key_up,
   input wire logic i_key_flow_style_setting,
   input wire logic i_digital_input_assignment,
   input wire logic i_item_editable,
   input wire logic i_item_is_string,
   input wire logic i_item_is_runready,
   input wire logic [1:0] o_item_group,
   input wire logic o_flashing,
   input wire logic [3:0] o_flash_digits,
   input wire logic o_commit,
   input wire logic o_mode_function,
   input wire logic o_mv_drive
);
   timeunit 1ns;
   timeprecision 1ps;
   // Raw idle starts before debounced idle, so a safe lower bound
   wire logic any_key = i_key_para | i_key_mode | i_key_shift
      | i_key_down | i_key_up;
   wire logic di_lock = i_item_is_runready & i_digital_input_assignment;
   logic [15:0] idle;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         idle <= 16'h0000;
      end else begin
         idle <= any_key ? 16'h0000 : idle + 16'h0001;
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   AST_COMMIT_ONE: assert property (o_commit |=> !o_commit)
      else $error("commit pulse longer than one cycle");
   AST_COMMIT_IDLE: assert property (o_commit |->
      $past(o_flashing) && 32'(idle) >= HOLD2_CYC)
      else $error("commit before idle time or outside edit");
   AST_LOCKED: assert property (
      $rose(o_flashing) |-> $past(i_item_editable))
      else $error("locked item started flashing");
   AST_DI_REFUSE: assert property (
      $rose(o_flashing) |-> !$past(di_lock))
      else $error("run ready edit while owned by input");
   AST_NUM_FIRST: assert property (
      $rose(o_flashing) && !i_item_is_string |-> o_flash_digits == 4'h1)
      else $error("numeric edit not on first digit");
   AST_STR_ALL: assert property (
      $rose(o_flashing) && i_item_is_string |-> o_flash_digits == 4'hF)
      else $error("string edit not whole string");
   AST_MODE_FN: assert property (
      o_mode_function |-> o_item_group == 2'h0 ##1 !o_mode_function)
      else $error("mode function pulse wrong");
   AST_BANK_STYLE: assert property (
      $changed(o_item_group) && o_item_group == 2'h3
      |-> i_key_flow_style_setting)
      else $error("bank group in standard style");
   AST_MV_HOLD: assert property (o_mv_drive |-> !o_commit)
      else $error("manual output edit committed");
   C_COMMIT: cover property (o_commit);
   C_MODE: cover property (o_mode_function);
   C_MV: cover property (o_mv_drive);
endmodule : ckec_checker

// [ckec_panel_model.sv]
/* Operator at the panel: key presses with contact chatter.
 Assumes the bench sets the wanted levels on a rising edge. */
module ckec_panel_model (
   input wire logic i_mclk,
   input wire logic [4:0] i_want,
   output logic [4:0] o_keys
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] prev = 5'h00;
   logic [4:0] mask = 5'h00;
   logic [1:0] bounce = 2'h0;
   initial o_keys = 5'h00;
   // Changed contacts chatter before settling
   always @(posedge i_mclk) begin
      if (i_want != prev) begin
         mask <= i_want ^ prev;
         prev <= i_want;
         bounce <= 2'h3;
      end else if (bounce != 2'h0) begin
         bounce <= bounce - 2'h1;
      end
      o_keys <= (bounce == 2'h0) ? prev : o_keys ^ mask;
   end
endmodule : ckec_panel_model

// [tb_console_key_edit_controller.sv]
/* Bench for ckec_top: keys via the panel model, item table here.
 Assumes shortened hold counts: debounce 4, 2 s 200, 1 s 100. */
`include "ckec_defines.svh"
module tb_console_key_edit_controller;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned H2 = 200;
   localparam int unsigned H1 = 100;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic [4:0] want = 5'h00;
   wire logic [4:0] keys;
   logic i_key_flow_style_setting = 1'b0;
   logic i_digital_input_assignment = 1'b0;
   logic i_manual_mode = 1'b0;
   logic i_item_present, i_item_last, i_item_editable, i_item_is_string;
   logic i_item_is_runready, i_item_is_mv;
   logic [15:0] i_item_value, i_choice_count;
   logic [1:0] o_item_group;
   logic [5:0] o_item_index;
   logic [3:0] o_flash_digits;
   logic [15:0] o_edit_value, o_manipulated_output_value;
   logic o_flashing, o_commit, o_mode_function, o_mv_drive;
   int bad_count = 0, comparisons = 0, cycles = 0, commits = 0, modes = 0;
   int n;
   always #2.5 i_mclk = ~i_mclk;
   ckec_panel_model panel (.i_mclk, .i_want(want), .o_keys(keys));
   ckec_top #(.DEBOUNCE_CYC(4), .HOLD2_CYC(H2), .HOLD1_CYC(H1)) dut (
      .i_mclk, .i_rst, .i_key_para(keys[0]), .i_key_mode(keys[1]),
      .i_key_shift(keys[2]), .i_key_down(keys[3]), .i_key_up(keys[4]),
      .i_key_flow_style_setting, .i_digital_input_assignment,
      .i_manual_mode, .i_item_present, .i_item_last, .i_item_editable,
      .i_item_is_string, .i_item_is_runready, .i_item_is_mv,
      .i_item_value, .i_choice_count, .o_item_group, .o_item_index,
      .o_flashing, .o_flash_digits, .o_edit_value, .o_commit,
      .o_mode_function, .o_mv_drive, .o_manipulated_output_value);
   // Item 1 absent, 2 string, 3 locked, 4 run/ready, 5 output, last
   always_comb begin
      i_item_present = o_item_index != 6'h01;
      i_item_last = o_item_index == 6'h05;
      i_item_editable = o_item_index != 6'h03;
      i_item_is_string = o_item_index == 6'h02 || o_item_index == 6'h04;
      i_item_is_runready = o_item_index == 6'h04;
      i_item_is_mv = o_item_index == 6'h05;
      i_item_value = i_item_is_string ? 16'h0000 : 16'h0123;
      i_choice_count = 16'h0003;
   end
   always @(posedge i_mclk) begin
      cycles++;
      if (o_commit === 1'b1) commits++;
      if (o_mode_function === 1'b1) modes++;
      if (cycles == 20000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done
   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
         input string what);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Waits cover chatter, sync, debounce and the edit latency
   task automatic key(input int k, input logic lvl);
      @(posedge i_mclk);
      want[k] <= lvl;
      repeat (20) @(posedge i_mclk);
   endtask : key
   task automatic tap(input int k);
      key(k, 1'b1);
      key(k, 1'b0);
   endtask : tap
   task automatic rst_dut();
      @(posedge i_mclk);
      i_rst <= 1'b1;
      want <= 5'h00;
      repeat (4) @(posedge i_mclk);
      i_rst <= 1'b0;
   endtask : rst_dut
   initial begin
      rst_dut();
      key(4, 1'b1);
      check(o_flashing, 1'b1, "flash start");
      check(o_edit_value, 16'h0123, "edit start");
      key(4, 1'b0);
      tap(2);
      check(o_flash_digits, 4'h2, "digit move");
      tap(4);
      check(o_edit_value, 16'h012D, "tens up");
      tap(2);
      check(o_flash_digits, 4'h4, "hundreds digit");
      tap(3);
      check(o_edit_value, 16'h00C9, "hundreds down");
      n = commits;
      repeat (H2 + 40) @(posedge i_mclk);
      check(16'(commits - n), 16'h0001, "commit count");
      check(o_edit_value, 16'h00C9, "commit value");
      check(o_flashing, 1'b0, "flash stop");
      $display("test numeric edit done");
      tap(0);
      check(o_item_index, 6'h02, "skip absent");
      tap(3);
      tap(3);
      check(o_flash_digits, 4'hF, "string flash");
      check(o_edit_value, 16'h0002, "previous choice");
      tap(4);
      check(o_edit_value, 16'h0000, "next choice wraps");
      n = commits;
      tap(0);
      check(o_flashing, 1'b0, "discard");
      check(o_item_index, 6'h03, "next item");
      tap(4);
      check(o_flashing, 1'b0, "locked");
      check(16'(commits - n), 16'h0000, "no commit");
      key(0, 1'b1);
      key(2, 1'b1);
      check(o_item_index, 6'h02, "reverse step");
      $display("test string edit done");
      rst_dut();
      i_digital_input_assignment <= 1'b1;
      i_manual_mode <= 1'b1;
      repeat (3) tap(0);
      tap(4);
      check(o_flashing, 1'b0, "run ready refused");
      tap(0);
      n = commits;
      tap(4);
      repeat (H2 + 60) @(posedge i_mclk);
      check(o_flashing, 1'b1, "output flashing");
      check(o_mv_drive, 1'b1, "output drive");
      check(o_manipulated_output_value, 16'h0123, "output");
      check(16'(commits - n), 16'h0000, "output no commit");
      tap(1);
      check(o_flashing, 1'b0, "mode discard");
      check(o_item_index, 6'h00, "operation display");
      $display("test refuse and output done");
      for (int s = 0; s < 2; s++) begin
         rst_dut();
         i_key_flow_style_setting <= s[0];
         key(0, 1'b1);
         repeat (H2 + 20) @(posedge i_mclk);
         check(o_item_group, s ? 2'h3 : 2'h2, "long advance");
      end
      rst_dut();
      n = modes;
      key(1, 1'b1);
      repeat (H1 + 20) @(posedge i_mclk);
      check(16'(modes - n), 16'h0001, "mode function");
      rst_dut();
      key(0, 1'b1);
      key(2, 1'b1);
      repeat (H2 + 20) @(posedge i_mclk);
      check(o_item_group, 2'h0, "chord ignored");
      $display("test hold keys done");
      test_done();
   end
endmodule : tb_console_key_edit_controller
bind ckec_top ckec_checker #(.HOLD2_CYC(HOLD2_CYC)) u_chk (
   .i_mclk, .i_rst, .i_key_para, .i_key_mode, .i_key_shift, .i_key_down,
   .i_key_up, .i_key_flow_style_setting, .i_digital_input_assignment,
   .i_item_editable, .i_item_is_string, .i_item_is_runready,
   .o_item_group, .o_flashing, .o_flash_digits, .o_commit,
   .o_mode_function, .o_mv_drive);
